/* File: design/lpcg_map.svh */
// Offsets, field positions, reset values and timing for the sleep controller.
// Included by the top-level design module only.
`ifndef LPCG_MAP_SVH
`define LPCG_MAP_SVH

// Register offsets (word index on the plain register port)
`define LPCG_OFS_CTRL 4'h0
`define LPCG_OFS_STAT 4'h1

// Control register fields
`define LPCG_PCLK_LSB 2
`define LPCG_PCLK_MSB 7
`define LPCG_DEPTH_LO 12
`define LPCG_DEPTH_HI 13
`define LPCG_FLASH_BIT 14
`define LPCG_CTRL_RST 16'h4000
`define LPCG_CTRL_MASK 16'h70FC

// Clock rate and wake-up settle times
`define LPCG_CLK_MHZ 100
`define LPCG_OSC_START_NS 1000
`define LPCG_PLL_LOCK_NS 2000
`define LPCG_OSC_CYC ((`LPCG_OSC_START_NS * `LPCG_CLK_MHZ + 999) / 1000)
`define LPCG_PLL_CYC ((`LPCG_PLL_LOCK_NS * `LPCG_CLK_MHZ + 999) / 1000)

`endif

/* File: design/lpcg_pkg.sv */
// Types shared by the sleep controller modules.
// Assumes lpcg_map.svh sits on the include path.
package lpcg_pkg;
  typedef enum logic [2:0] {
    LPCG_RUN = 3'b000,
    LPCG_LIGHT = 3'b001,
    LPCG_DEEP = 3'b010,
    LPCG_HALT = 3'b011,
    LPCG_OSC_WAIT = 3'b100,
    LPCG_PLL_WAIT = 3'b101
  } lpcg_state_e;

  typedef logic [15:0] lpcg_word_t;
endpackage : lpcg_pkg

/* File: design/lpcg_settle.sv */
// Down counter that signals when a settle period has elapsed.
// Assumes a single clock; i_start is a one-cycle pulse.
`timescale 1ns/1ns
module lpcg_settle #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_cycles,
  // Status
  output logic o_busy,
  output logic o_done
);
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  initial begin
    if (WIDTH < 2) $error("lpcg_settle: WIDTH too small");
  end

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (i_start) begin
      cnt_d = i_cycles;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= WIDTH'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule : lpcg_settle

/* File: design/lpcg_top.sv */
// Low-power mode and clock-gating controller.
// Assumes the core pulses i_idle_exec when it runs the idle instruction
// and that all inputs are synchronous to i_clk.
// Function
// - Idle stops all processor clocks; system clock output keeps running in light sleep only
// - Idle ends on processor reset or an interrupt request
// - Two domains: processor logic, and system for peripherals and interrupts
// - Sleep depth field [13:12]: 00 light, 01 deep, 1X halt
// - Light sleep stops processor domain only; wake on many sources
// - Deep sleep stops both domains; watchdog, PLL, oscillator, flash on (flash power follows control bit 14 in every state)
// - Deep sleep exits on wake, external interrupt, reset or drive protect
// - Halt also stops oscillator, watchdog, PLL; only reset or protect wake
// - Six peripheral clock enables, all disabled after reset
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "lpcg_map.svh"
module lpcg_top
  import lpcg_pkg::*;
#(
  parameter int NUM_PCLK = 6,
  parameter int OSC_CYC = `LPCG_OSC_CYC,
  parameter int PLL_CYC = `LPCG_PLL_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Core and wake sources
  input wire logic i_idle_exec,
  input wire logic i_core_rst,
  input wire logic i_periph_irq,
  input wire logic i_ext_irq,
  input wire logic i_wakeup_irq,
  input wire logic i_power_drive_protect_int,
  // Clock and power controls
  output logic o_cpu_clk_en,
  output logic o_system_clock_out_en,
  output logic o_watchdog_clock_en,
  output logic o_pll_en,
  output logic o_osc_en,
  output logic o_flash_pwr,
  output logic [NUM_PCLK-1:0] o_periph_clk_en
);
  localparam int PW = `LPCG_PCLK_MSB - `LPCG_PCLK_LSB + 1;

  initial begin
    if (NUM_PCLK != PW) $error("lpcg_top: NUM_PCLK must match field");
    if (OSC_CYC < 1 || OSC_CYC > 65535) $error("lpcg_top: bad OSC_CYC");
    if (PLL_CYC < 1 || PLL_CYC > 65535) $error("lpcg_top: bad PLL_CYC");
  end

  lpcg_state_e state_q, state_d;
  lpcg_word_t ctrl_q, ctrl_d;
  lpcg_word_t rdata_q, rdata_d;
  logic cpu_q, cpu_d, sys_q, sys_d;
  logic wdog_q, wdog_d, pll_q, pll_d, osc_q, osc_d;
  logic [NUM_PCLK-1:0] pclk_q, pclk_d;
  logic tmr_start;
  logic [15:0] tmr_cycles;
  logic tmr_busy, tmr_done;
  logic [1:0] depth;
  logic wake_light, wake_deep, wake_halt;

  function automatic lpcg_state_e depth_state(input logic [1:0] sel);
    if (sel[1]) return LPCG_HALT;
    return sel[0] ? LPCG_DEEP : LPCG_LIGHT;
  endfunction : depth_state

  assign depth = ctrl_q[`LPCG_DEPTH_HI:`LPCG_DEPTH_LO];
  assign wake_light = i_periph_irq | i_ext_irq | i_core_rst
    | i_power_drive_protect_int;
  assign wake_deep = i_wakeup_irq | i_ext_irq | i_core_rst
    | i_power_drive_protect_int;
  assign wake_halt = i_core_rst | i_power_drive_protect_int;

  lpcg_settle #(
    .WIDTH(16)
  ) u_lpcg_settle (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(tmr_start),
    .i_cycles(tmr_cycles),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // Sleep sequencer and clock enables
  always_comb begin
    state_d = state_q;
    tmr_start = 1'b0;
    tmr_cycles = 16'(OSC_CYC);
    unique case (state_q)
      LPCG_RUN: begin
        if (i_idle_exec) state_d = depth_state(depth);
      end
      LPCG_LIGHT: begin
        if (wake_light) state_d = LPCG_RUN;
      end
      LPCG_DEEP: begin
        if (wake_deep) state_d = LPCG_RUN;
      end
      LPCG_HALT: begin
        if (wake_halt) begin
          state_d = LPCG_OSC_WAIT;
          tmr_start = 1'b1;
        end
      end
      LPCG_OSC_WAIT: begin
        if (tmr_done) begin
          state_d = LPCG_PLL_WAIT;
          tmr_start = 1'b1;
          tmr_cycles = 16'(PLL_CYC);
        end
      end
      LPCG_PLL_WAIT: begin
        if (tmr_done) state_d = LPCG_RUN;
      end
      default: state_d = LPCG_RUN;
    endcase
    cpu_d = (state_d == LPCG_RUN);
    sys_d = (state_d == LPCG_RUN) || (state_d == LPCG_LIGHT);
    osc_d = (state_d != LPCG_HALT);
    pll_d = osc_d && (state_d != LPCG_OSC_WAIT);
    wdog_d = pll_d;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= LPCG_RUN;
      cpu_q <= 1'b1;
      sys_q <= 1'b1;
      wdog_q <= 1'b1;
      pll_q <= 1'b1;
      osc_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cpu_q <= cpu_d;
      sys_q <= sys_d;
      wdog_q <= wdog_d;
      pll_q <= pll_d;
      osc_q <= osc_d;
    end
  end

  // Register port
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = 16'h0000;
    if (i_wr && i_addr == `LPCG_OFS_CTRL) begin
      ctrl_d = i_wdata & `LPCG_CTRL_MASK;
    end
    if (i_rd) begin
      unique case (i_addr)
        `LPCG_OFS_CTRL: rdata_d = ctrl_q;
        `LPCG_OFS_STAT: rdata_d = {8'h00, tmr_busy, 1'b0,
          o_osc_en, o_pll_en, o_system_clock_out_en, state_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    pclk_d = ctrl_d[`LPCG_PCLK_MSB:`LPCG_PCLK_LSB] & {NUM_PCLK{sys_d}};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `LPCG_CTRL_RST;
      rdata_q <= 16'h0000;
      pclk_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      pclk_q <= pclk_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_cpu_clk_en = cpu_q;
  assign o_system_clock_out_en = sys_q;
  assign o_watchdog_clock_en = wdog_q;
  assign o_pll_en = pll_q;
  assign o_osc_en = osc_q;
  assign o_flash_pwr = ctrl_q[`LPCG_FLASH_BIT];
  assign o_periph_clk_en = pclk_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_light_domains: assert property (
    state_q == LPCG_LIGHT |-> !o_cpu_clk_en && o_system_clock_out_en
      && o_pll_en && o_osc_en && o_watchdog_clock_en)
    else $error("light sleep clock enables wrong");
  a_deep_domains: assert property (
    state_q == LPCG_DEEP |-> !o_cpu_clk_en && !o_system_clock_out_en
      && o_pll_en && o_osc_en && o_watchdog_clock_en)
    else $error("deep sleep clock enables wrong");
  a_halt_all_off: assert property (
    state_q == LPCG_HALT |-> !o_osc_en && !o_pll_en
      && !o_watchdog_clock_en && !o_system_clock_out_en)
    else $error("halt left a clock running");
  a_halt_only_wake: assert property (
    state_q == LPCG_HALT && !i_core_rst && !i_power_drive_protect_int
      |=> state_q == LPCG_HALT)
    else $error("halt woke on a wrong source");
  a_depth_select: assert property (
    state_q == LPCG_RUN && i_idle_exec && depth == 2'b01
      |=> state_q == LPCG_DEEP && !o_cpu_clk_en)
    else $error("depth 01 did not enter deep sleep");
  a_light_wake: assert property (
    state_q == LPCG_LIGHT && i_periph_irq |=> o_cpu_clk_en)
    else $error("light sleep missed interrupt wake");
  a_deep_wake: assert property (
    state_q == LPCG_DEEP && i_ext_irq |=> state_q == LPCG_RUN)
    else $error("deep sleep missed external wake");
  a_relock_order: assert property (
    state_q == LPCG_HALT && i_power_drive_protect_int
      |=> o_osc_en && !o_pll_en && !o_cpu_clk_en
      ##1 (!o_cpu_clk_en)[*2])
    else $error("halt wake enabled clocks too early");
  a_pclk_gate: assert property (
    (o_periph_clk_en & ~$past(ctrl_q[`LPCG_PCLK_MSB:`LPCG_PCLK_LSB]))
      == '0 || $past(i_wr))
    else $error("peripheral clock on without enable");
  a_idle_cpu_off: assert property (
    state_q == LPCG_RUN && i_idle_exec && depth == 2'b00
      |=> !o_cpu_clk_en && o_system_clock_out_en)
    else $error("light idle stopped the wrong clocks");
endmodule : lpcg_top

/* File: verif/lpcg_core.sv */
// Core model: runs the idle instruction as a one-cycle pulse.
// Assumes the bench clock; idle is only run while the core is clocked.
`timescale 1ns/1ns
module lpcg_core (
  // Clock
  input wire logic i_clk,
  // Core clock state
  input wire logic i_cpu_clk_en,
  // Idle request
  output logic o_idle_exec
);
  initial o_idle_exec = 1'b0;

  task automatic idle();
    wait (i_cpu_clk_en === 1'b1);
    @(posedge i_clk);
    o_idle_exec <= 1'b1;
    @(posedge i_clk);
    o_idle_exec <= 1'b0;
  endtask : idle
endmodule : lpcg_core

/* File: verif/test_low_power_clock_gating.sv */
// Bench for the sleep controller: registers, sleep depths, wake sources.
// Assumes lpcg_pkg is compiled first and the core model is available.
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h not %h", $time, (a), (e)); end end
module test_low_power_clock_gating;
  import lpcg_pkg::*;
  localparam int OSC = 3;
  localparam int PLL = 4;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  lpcg_word_t i_wdata = 16'h0000;
  logic [4:0] wk = 5'h00;
  logic idle, cpu, sys, wdog, pll, osc, flash;
  logic [5:0] pclk;
  lpcg_word_t rdata;
  int errors = 0;
  int comparisons = 0;

  always #5 i_clk = ~i_clk;

  lpcg_top #(.NUM_PCLK(6), .OSC_CYC(OSC), .PLL_CYC(PLL)) u_lpcg_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_idle_exec(idle),
    .i_core_rst(wk[4]), .i_periph_irq(wk[0]), .i_ext_irq(wk[1]),
    .i_wakeup_irq(wk[2]), .i_power_drive_protect_int(wk[3]),
    .o_cpu_clk_en(cpu), .o_system_clock_out_en(sys),
    .o_watchdog_clock_en(wdog), .o_pll_en(pll), .o_osc_en(osc),
    .o_flash_pwr(flash), .o_periph_clk_en(pclk));
  lpcg_core u_lpcg_core (.i_clk(i_clk), .i_cpu_clk_en(cpu),
    .o_idle_exec(idle));

  task automatic wr(input logic [3:0] a, input lpcg_word_t d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input lpcg_word_t e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge i_clk);
    #1;
    `CHK(rdata, 16'h0000)
  endtask : rd

  task automatic t_reset();
    `CHK({cpu, sys, wdog, pll, osc, flash}, 6'h3F)
    `CHK(pclk, 6'h00)
    rd(4'h0, 16'h4000);
    rd(4'h1, 16'h0038);
    rd(4'hF, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'h0, 16'h4000);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'h70FC);
    `CHK(pclk, 6'h3F)
  endtask : t_reset

  // One sleep of depth d, woken by source s (or by protect if s is ignored)
  task automatic nap(input logic [1:0] d, input int s);
    logic [4:0] m;
    logic on;
    int n;
    int p;
    m = d[1] ? 5'h18 : (d[0] ? 5'h1E : 5'h1B);
    on = (d == 2'b00);
    n = 0;
    p = 0;
    wr(4'h0, {1'b0, ~d[1], d, 12'h0FC});
    u_lpcg_core.idle();
    #1;
    `CHK(cpu, 1'b0)
    `CHK(sys, on)
    `CHK({wdog, pll, osc}, {3{~d[1]}})
    `CHK(pclk, on ? 6'h3F : 6'h00)
    `CHK(flash, ~d[1])
    @(posedge i_clk);
    wk[s] <= 1'b1;
    @(posedge i_clk);
    #1;
    if (!m[s]) begin
      `CHK(cpu, 1'b0)
      `CHK(osc, ~d[1])
      @(posedge i_clk);
      wk <= 5'h08;
      @(posedge i_clk);
      #1;
    end
    `CHK(osc, 1'b1)
    `CHK(pll, ~d[1])
    `CHK(cpu, ~d[1])
    while (cpu !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      wk <= 5'h00;
      #1;
      n++;
      if (pll === 1'b1 && p == 0) begin
        p = n;
        `CHK(sys, 1'b0)
      end
    end
    @(posedge i_clk);
    wk <= 5'h00;
    #1;
    if (d[1]) begin
      `CHK(p, OSC + 1)
      `CHK(n, OSC + PLL + 2)
    end
    `CHK({cpu, sys, pclk}, 8'hFF)
    `CHK(flash, ~d[1])
  endtask : nap

  task automatic t_rerst();
    wr(4'h0, 16'h50FC);
    u_lpcg_core.idle();
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `CHK({cpu, sys, pclk}, 8'hC0)
    rd(4'h0, 16'h4000);
  endtask : t_rerst

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    for (int d = 0; d < 4; d++) begin
      for (int s = 0; s < 5; s++) begin
        nap(d[1:0], s);
      end
    end
    t_rerst();
    test_done();
  end

  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule : test_low_power_clock_gating
